/* File: core/ssrw_pkg.sv */
/*
  Constants for the supply supervisor with reset stretcher and watchdog.
  Assumes a 100 MHz free-running internal time base; analog comparators sit outside
  and deliver digital levels.
*/
// How it works
// - Reset held while low, released after 200 ms
// - Undervoltage during operation starts reset pulse
// - New undervoltage restarts running reset pulse
// - Active-high reset is exact complement
// - Fault low after 1.6 s without toggle
// - Watchdog cleared during reset or floating kick
// - Watchdog counts once released and kick driven
// - Undervoltage forces fault output low
// - Undervoltage asserts reset and fault in same cycle
// - Floating kick makes fault a low-line flag
// - Manual reset low gives >= 140 ms pulse
// - Power-fail flag low when sense below reference
package ssrw_pkg;
  localparam longint CLK_HZ = 64'd100_000_000;
  localparam longint RESET_PULSE_MS = 64'd200;
  localparam longint WATCHDOG_MS = 64'd1600;
  localparam longint KICK_MIN_NS = 64'd50;
  localparam int unsigned RESET_PULSE_CYC = 32'(RESET_PULSE_MS * CLK_HZ / 64'd1000);
  localparam int unsigned WATCHDOG_CYC = 32'(WATCHDOG_MS * CLK_HZ / 64'd1000);
  localparam int unsigned KICK_MIN_CYC = 32'((KICK_MIN_NS * CLK_HZ + 64'd999_999_999)
                                             / 64'd1_000_000_000);
  localparam int unsigned SYNC_STAGES = 32'd2;
endpackage : ssrw_pkg

/* File: core/ssrw_sync.sv */
/*
  Two-flop level synchroniser for asynchronous pins.
  Assumes the input is a plain level; nothing reads the first stage except the second.
*/
`timescale 1ns/1ns
module ssrw_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;
  logic meta_next;
  logic sync_reg;
  logic sync_next;

  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : ssrw_sync

/* File: core/ssrw_supervisor.sv */
/*
  Supply supervisor: reset pulse stretcher, watchdog and power-fail flag.
  Assumes undervoltage, power-fail and floating-kick indications come from analog
  comparators outside as digital levels, asynchronous to ref_clk_in. The clock is
  a free-running internal oscillator; nothing but sys_rst_in resets the registers.
  Every pin passes a two-flop synchroniser, so each response lags its cause by
  three clock edges; pulses shorter than one cycle may be missed.
  Variants with only one reset polarity leave the unused output open.
  The watchdog counts only while reset is released and the kick pin is driven.
*/
`timescale 1ns/1ns
module ssrw_supervisor #(
  parameter int unsigned RESET_CYCLES = ssrw_pkg::RESET_PULSE_CYC,
  parameter int unsigned WATCHDOG_CYCLES = ssrw_pkg::WATCHDOG_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic supply_low_in,
  input wire logic manual_reset_n_in,
  input wire logic watchdog_kick_in,
  input wire logic kick_floating_in,
  input wire logic power_fail_sense_in,
  output logic reset_n_out,
  output logic reset_out,
  output logic watchdog_fault_n_out,
  output logic power_fail_n_out
);
  localparam int RW = $clog2(RESET_CYCLES + 1);
  localparam int WW = $clog2(WATCHDOG_CYCLES + 1);

  logic uv_s;
  logic mr_n_s;
  logic kick_s;
  logic float_s;
  logic pfi_s;

  // Undervoltage comes up asserted so reset cannot slip out before the pin is seen
  ssrw_sync #(.RESET_VALUE(1'b1)) u_sync_uv (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(supply_low_in),
    .sync_out(uv_s)
  );

  ssrw_sync #(.RESET_VALUE(1'b1)) u_sync_mr (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(manual_reset_n_in),
    .sync_out(mr_n_s)
  );

  ssrw_sync #(.RESET_VALUE(1'b0)) u_sync_kick (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(watchdog_kick_in),
    .sync_out(kick_s)
  );

  ssrw_sync #(.RESET_VALUE(1'b1)) u_sync_float (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(kick_floating_in),
    .sync_out(float_s)
  );

  ssrw_sync #(.RESET_VALUE(1'b1)) u_sync_pfi (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in(power_fail_sense_in),
    .sync_out(pfi_s)
  );

  // Stretch counts RESET_CYCLES cycles from zero; RUN means reset released
  typedef enum logic [1:0] {
    SSRW_HOLD,
    SSRW_STRETCH,
    SSRW_RUN
  } ssrw_state_t;

  ssrw_state_t state_reg;
  ssrw_state_t state_next;
  logic [RW-1:0] rst_cnt_reg;
  logic [RW-1:0] rst_cnt_next;
  logic [WW-1:0] wd_cnt_reg;
  logic [WW-1:0] wd_cnt_next;
  logic wd_timeout_reg;
  logic wd_timeout_next;
  logic kick_prev_reg;
  logic kick_prev_next;
  logic reset_n_reg;
  logic reset_n_next;
  logic wdo_n_reg;
  logic wdo_n_next;
  logic pf_n_reg;
  logic pf_n_next;

  // Terminal count of a timer that counts from zero
  function automatic logic ssrw_at_last(input int unsigned count, input int unsigned limit);
    return count == limit - 32'd1;
  endfunction : ssrw_at_last

  // Each group of state has one next-value process and one register process
  logic hold_cause;
  logic kick_edge;

  // Reset pulse: held during undervoltage or manual low, stretched after release
  always_comb begin
    hold_cause = uv_s | ~mr_n_s;
    state_next = state_reg;
    rst_cnt_next = rst_cnt_reg;
    case (state_reg)
      SSRW_HOLD: begin
        rst_cnt_next = '0;
        if (!hold_cause) begin
          state_next = SSRW_STRETCH;
        end
      end
      SSRW_STRETCH: begin
        if (hold_cause) begin
          // Restarting from zero guarantees the full interval after the new event
          state_next = SSRW_HOLD;
          rst_cnt_next = '0;
        end else if (ssrw_at_last(32'(rst_cnt_reg), RESET_CYCLES)) begin
          state_next = SSRW_RUN;
        end else begin
          rst_cnt_next = rst_cnt_reg + RW'(1);
        end
      end
      SSRW_RUN: begin
        if (hold_cause) begin
          state_next = SSRW_HOLD;
        end
      end
      default: begin
        state_next = SSRW_HOLD;
        rst_cnt_next = '0;
      end
    endcase
    // Reset drops combinationally with the hold cause so it matches the fault output
    reset_n_next = (state_next == SSRW_RUN);
  end

  // Kick edge detector; its reset value matches the kick synchroniser so reset
  // release cannot fake an edge
  always_comb begin
    kick_prev_next = kick_s;
    kick_edge = kick_s ^ kick_prev_reg;
  end

  // Watchdog: the timeout sticks until a kick edge, a reset or a floating pin
  always_comb begin
    wd_cnt_next = wd_cnt_reg;
    wd_timeout_next = wd_timeout_reg;
    if (!reset_n_reg || float_s) begin
      wd_cnt_next = '0;
      wd_timeout_next = 1'b0;
    end else if (kick_edge) begin
      wd_cnt_next = '0;
      wd_timeout_next = 1'b0;
    end else if (ssrw_at_last(32'(wd_cnt_reg), WATCHDOG_CYCLES)) begin
      // Counter parks here so it cannot wrap and fake a fresh interval
      wd_timeout_next = 1'b1;
    end else begin
      wd_cnt_next = wd_cnt_reg + WW'(1);
    end
    // Undervoltage forces the fault low in the same cycle reset drops
    wdo_n_next = ~(uv_s | wd_timeout_next);
  end

  // Power-fail flag: a plain registered copy of the synchronised comparator
  always_comb begin
    pf_n_next = pfi_s;
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= SSRW_HOLD;
      rst_cnt_reg <= '0;
      reset_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      rst_cnt_reg <= rst_cnt_next;
      reset_n_reg <= reset_n_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      kick_prev_reg <= 1'b0;
    end else begin
      kick_prev_reg <= kick_prev_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wd_cnt_reg <= '0;
      wd_timeout_reg <= 1'b0;
      wdo_n_reg <= 1'b1;
    end else begin
      wd_cnt_reg <= wd_cnt_next;
      wd_timeout_reg <= wd_timeout_next;
      wdo_n_reg <= wdo_n_next;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pf_n_reg <= 1'b1;
    end else begin
      pf_n_reg <= pf_n_next;
    end
  end

  assign reset_n_out = reset_n_reg;
  assign reset_out = ~reset_n_reg;
  assign watchdog_fault_n_out = wdo_n_reg;
  assign power_fail_n_out = pf_n_reg;
endmodule : ssrw_supervisor

/* File: verification/ssrw_checker.sv */
/* Port checker bound to ssrw_supervisor.
   Assumes raw asynchronous pins; windows absorb synchroniser lag. */
`timescale 1ns/1ns
module ssrw_checker #(parameter int unsigned RESET_CYCLES = 20, WATCHDOG_CYCLES = 50) (
  input wire logic ref_clk_in, sys_rst_in, supply_low_in, manual_reset_n_in,
  input wire logic watchdog_kick_in, kick_floating_in, power_fail_sense_in,
  input wire logic reset_n_out, reset_out, watchdog_fault_n_out, power_fail_n_out
);
  logic [31:0] gap_reg, idle_reg;
  logic kick_reg;
  always_ff @(posedge ref_clk_in) begin
    kick_reg <= watchdog_kick_in;
    gap_reg <= (sys_rst_in | supply_low_in | ~manual_reset_n_in) ? '0 : gap_reg + 1;
    idle_reg <= (~reset_n_out | kick_floating_in | kick_reg ^ watchdog_kick_in) ? '0 : idle_reg + 1;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_out_pair: assert property (reset_out == ~reset_n_out)
    else $error("reset pair");
  a_uv_both_low: assert property (supply_low_in [*4] |-> !reset_n_out && !watchdog_fault_n_out)
    else $error("undervoltage");
  a_manual_hold: assert property (!manual_reset_n_in [*4] |-> !reset_n_out)
    else $error("manual hold");
  a_stretch_len: assert property ($rose(reset_n_out) |-> gap_reg >= RESET_CYCLES && gap_reg <= RESET_CYCLES + 6)
    else $error("stretch");
  a_wd_early: assert property ($fell(watchdog_fault_n_out) && reset_n_out |-> idle_reg >= WATCHDOG_CYCLES - 2)
    else $error("early fault");
  a_wd_late: assert property (reset_n_out && idle_reg == WATCHDOG_CYCLES + 8 |-> !watchdog_fault_n_out)
    else $error("late fault");
  a_float_quiet: assert property ((kick_floating_in && !supply_low_in) [*8] |-> watchdog_fault_n_out)
    else $error("floating");
  a_pf_follow: assert property (!$past(sys_rst_in, 4) |-> power_fail_n_out == $past(power_fail_sense_in, 3))
    else $error("power fail");
  c_wd: cover property ($fell(watchdog_fault_n_out) && reset_n_out);
  c_rel: cover property ($rose(reset_n_out));
  c_pf: cover property ($fell(power_fail_n_out));
endmodule : ssrw_checker
bind ssrw_supervisor ssrw_checker #(.RESET_CYCLES(RESET_CYCLES), .WATCHDOG_CYCLES(WATCHDOG_CYCLES))
  chk_i (.ref_clk_in, .sys_rst_in, .supply_low_in, .manual_reset_n_in, .watchdog_kick_in,
  .kick_floating_in, .power_fail_sense_in, .reset_n_out, .reset_out, .watchdog_fault_n_out,
  .power_fail_n_out);

/* File: verification/ssrw_cpu_model.sv */
/* Processor model: toggles the kick pin every half_in+1 cycles while driving it.
   Assumes half_in of at least five while driving. */
`timescale 1ns/1ns
module ssrw_cpu_model (
  input wire logic ref_clk_in,
  input wire logic drive_in,
  input wire logic [7:0] half_in,
  output logic kick_out,
  output logic floating_out
);
  logic [7:0] cnt_reg = 8'h00;
  logic level_reg = 1'b0;
  always @(posedge ref_clk_in) begin
    cnt_reg <= (cnt_reg >= half_in) ? 8'h00 : cnt_reg + 8'h01;
    if (drive_in && cnt_reg >= half_in) level_reg <= ~level_reg;
  end
  // A released pin settles opposite to the last driven level and then stays put,
  // so only the floating detection can keep the watchdog quiet
  assign kick_out = drive_in ? level_reg : ~level_reg;
  assign floating_out = ~drive_in;
endmodule : ssrw_cpu_model

/* File: verification/supply_supervisor_reset_watchdog_test.sv */
/* Bench for ssrw_supervisor with a processor model on the kick pin.
   Assumes shortened counts RC and WC. */
`timescale 1ns/1ns
module supply_supervisor_reset_watchdog_test;
  localparam int RC = 20;
  localparam int WC = 50;
  logic c = 1'b0, rs = 1'b1, uv = 1'b0, mr_n = 1'b1, pf = 1'b1, dr = 1'b1;
  logic [7:0] h = 8'h05;
  logic k, f, q_n, qh, w_n, p_n;
  int errors = 0, comparisons = 0, n;
  always #5 c = ~c;
  ssrw_cpu_model cpu (.ref_clk_in(c), .drive_in(dr), .half_in(h), .kick_out(k), .floating_out(f));
  ssrw_supervisor #(.RESET_CYCLES(RC), .WATCHDOG_CYCLES(WC)) dut (.ref_clk_in(c), .sys_rst_in(rs),
    .supply_low_in(uv), .manual_reset_n_in(mr_n), .watchdog_kick_in(k), .kick_floating_in(f),
    .power_fail_sense_in(pf), .reset_n_out(q_n), .reset_out(qh), .watchdog_fault_n_out(w_n),
    .power_fail_n_out(p_n));
  task automatic end_sim;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  function automatic logic near(input int v, input int lo);
    return v >= lo && v <= lo + 10;
  endfunction : near
  // Waits on reset (sel low) or fault (sel high); a hang ends the run
  task automatic wait_on(input logic sel, input logic v);
    for (n = 0; (sel ? w_n : q_n) !== v; n++) begin
      if (n == 1000) begin
        chk(1'b0, "timeout");
        end_sim;
      end
      @(posedge c);
    end
  endtask : wait_on
  initial begin
    void'($urandom(16));
    repeat (20) @(posedge c);
    rs <= 1'b0;
    chk(q_n === 1'b0 && qh === 1'b1, "reset state");
    wait_on(1'b0, 1'b1);
    chk(near(n, RC), "power-up");
    $display("power-up test done");
    h <= 8'hff;
    wait_on(1'b1, 1'b0);
    chk(near(n, WC - 4), "no kick");
    h <= 8'h05;
    wait_on(1'b1, 1'b1);
    chk(n < 12, "kick");
    dr <= 1'b0;
    repeat (2 * WC) @(posedge c);
    chk(w_n === 1'b1, "floating");
    dr <= 1'b1;
    $display("watchdog test done");
    // Odd passes use undervoltage, even passes the manual input; each restarts mid-stretch
    for (int i = 0; i < 4; i++) begin
      uv <= i[0];
      mr_n <= i[0];
      repeat (8 + $urandom_range(20)) @(posedge c);
      chk(q_n === 1'b0 && w_n === !i[0], "cause");
      uv <= 1'b0;
      mr_n <= 1'b1;
      repeat (4 + $urandom_range(12)) @(posedge c);
      uv <= i[0];
      mr_n <= i[0];
      repeat (6) @(posedge c);
      uv <= 1'b0;
      mr_n <= 1'b1;
      wait_on(1'b0, 1'b1);
      chk(near(n, RC), "stretch");
    end
    repeat (20) begin
      pf <= 1'($urandom_range(1));
      repeat (5) @(posedge c);
      chk(p_n === pf, "power fail");
    end
    $display("supply tests done");
    end_sim;
  end
endmodule : supply_supervisor_reset_watchdog_test
